// File: rtl/speed_limit_monitor_ramp_stop.sv
`timescale 1ns/10ps
`include "slm_cfg.svh"

// How it works
// - Over limit raises message, internal event goes 0
// - Internal event changes on first message only
// - Violation starts ramp stop, then torque off
// - Ramp stop decelerates on fast stop ramp
// - Torque off at shutdown speed or timer
// - Stop status bit 12 during either stop
// - Safety status bit 0 while torque off
// - Safety status bit 1 while ramp stop
// - Report monitor active bit 4 except in standstill, level bits 9-10
// - Limit taken from table by active level
// - Both channels report exceeded level message
// - Both channels report ramp, then cancel messages
// - Switch-on inhibit held until acknowledged
// - Monitor only when enabled and commissioning zero
// - Other response: stop and hold, then standstill
module speed_limit_monitor_ramp_stop
	import slm_pkg::*;
#(
	parameter int SPEED_W = 32,
	parameter int HOLD_CYCLES = `HOLD_CYCLES
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic tick_i,
	input wire logic [`CHANNELS-1:0][SPEED_W-1:0] speed_i,
	output logic fast_stop_o,
	output logic torque_off_o,
	output logic standstill_mon_o,
	output logic inhibit_o,
	output logic [`CHANNELS-1:0] msg_limit_o,
	output logic [`CHANNELS-1:0] msg_ramp_o,
	output logic [`CHANNELS-1:0] msg_cancel_o,
	output logic [15:0] msg_value_o,
	output logic irq_o
);

	stop_state_type state_q, state_d;
	logic [31:0] control_q, config_q, ramp_time_q, timer_q, irq_status_q, irq_mask_q, rdata_q;
	logic [SPEED_W-1:0] table_q [`LEVELS];
	logic [SPEED_W-1:0] shutdown_q, limit_sel;
	logic [1:0] level_q, msg_level_q;
	logic [`CHANNELS-1:0] msg_limit_q, msg_ramp_q, msg_cancel_q, exceeded, below;
	logic event_q, inhibit_q, mon_en, mon_active, armed, violation, ack_msg, ack_inhibit, msgs_clear, ramp_done;
	response_type response;
	logic [31:0] safety_status, stop_status, messages, events;
	logic [15:0] msg_value;

	// Enable gating from the configuration word, selection from the control word
	assign mon_en = config_q[`CFG_SAFETY_EN_BIT] && config_q[`CFG_EXT_EN_BIT]
		&& (config_q[`CFG_COMM_HI:`CFG_COMM_LO] == 8'h00);
	assign mon_active = mon_en && control_q[`CTRL_SELECT_BIT];
	assign response = response_type'(config_q[`CFG_RESPONSE_BIT]);
	assign armed = mon_active && (state_q == ST_RUN);
	assign limit_sel = table_q[level_q];
	assign violation = (|exceeded) && armed;

	// Command pulses from the register port
	assign ack_msg = wr_i && (addr_i == `ADDR_COMMAND) && wdata_i[`CMD_ACK_MSG_BIT]
		&& !control_q[`CTRL_SELECT_BIT];
	assign msgs_clear = (msg_limit_q == '0) && (msg_ramp_q == '0) && (msg_cancel_q == '0);
	assign ack_inhibit = wr_i && (addr_i == `ADDR_COMMAND) && wdata_i[`CMD_ACK_INHIBIT_BIT]
		&& msgs_clear;
	assign ramp_done = (tick_i && (&below)) || (timer_q >= ramp_time_q);

	// One comparator per monitoring channel
	for (genvar g = 0; g < `CHANNELS; g++) begin : g_chan
		limit_if #(.WIDTH(SPEED_W)) link ();
		assign link.tick = tick_i;
		assign link.armed = armed;
		assign link.speed = speed_i[g];
		assign link.limit = limit_sel;
		assign link.floor = shutdown_q;
		assign exceeded[g] = link.exceeded;
		assign below[g] = link.below;
		limit_compare #(.WIDTH(SPEED_W)) u_cmp (
			.clk_i(mclk_i),
			.rst_i(rst_i),
			.port(link.compare)
		);
	end

	// Next state of the stop sequence
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_RUN: begin
				if (violation) begin
					state_d = (response == RESP_RAMP_STOP) ? ST_RAMP : ST_HOLD;
				end
			end
			ST_RAMP: begin
				if (ramp_done) begin
					state_d = ST_CANCEL;
				end
			end
			ST_CANCEL: begin
				if (ack_inhibit && !control_q[`CTRL_SELECT_BIT]) begin
					state_d = ST_RUN;
				end
			end
			ST_HOLD: begin
				if (timer_q >= 32'(HOLD_CYCLES)) begin
					state_d = ST_STANDSTILL;
				end
			end
			ST_STANDSTILL: begin
				if (msgs_clear && !control_q[`CTRL_SELECT_BIT]) begin
					state_d = ST_RUN;
				end
			end
			default: begin
				state_d = ST_CANCEL;
			end
		endcase
	end

	// State register
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			state_q <= ST_RUN;
		end else begin
			state_q <= state_d;
		end
	end
	// Stop timer restarts on every state change
	always_ff @(posedge mclk_i) begin
		if (rst_i || (state_d != state_q)) begin
			timer_q <= 32'h0000_0000;
		end else if ((state_q == ST_RAMP || state_q == ST_HOLD) && (timer_q != 32'hFFFF_FFFF)) begin
			timer_q <= timer_q + 32'h0000_0001;
		end
	end
	// Active level follows the selection only while running
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			level_q <= 2'b00;
		end else if (state_q == ST_RUN) begin
			level_q <= control_q[`CTRL_LEVEL_HI:`CTRL_LEVEL_LO];
		end
	end

	// Safety messages on both channels; a new set wins over an acknowledge
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			msg_limit_q <= '0;
			msg_ramp_q <= '0;
			msg_cancel_q <= '0;
			msg_level_q <= 2'b00;
		end else begin
			if (violation) begin
				msg_limit_q <= '1;
				msg_level_q <= level_q;
			end else if (ack_msg) begin
				msg_limit_q <= '0;
			end
			if (state_q == ST_RUN && state_d == ST_RAMP) begin
				msg_ramp_q <= '1;
			end else if (ack_msg) begin
				msg_ramp_q <= '0;
			end
			if (state_q == ST_RAMP && state_d == ST_CANCEL) begin
				msg_cancel_q <= '1;
			end else if (ack_msg) begin
				msg_cancel_q <= '0;
			end
		end
	end

	// Internal event drops on the first message, rises on acknowledge
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			event_q <= 1'b1;
		end else if (violation && msgs_clear) begin
			event_q <= 1'b0;
		end else if (ack_msg && !violation) begin
			event_q <= 1'b1;
		end
	end
	// Switch-on inhibit latched at torque off
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			inhibit_q <= 1'b0;
		end else if (state_q == ST_RAMP && state_d == ST_CANCEL) begin
			inhibit_q <= 1'b1;
		end else if (ack_inhibit) begin
			inhibit_q <= 1'b0;
		end
	end

	// Software-written configuration
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			control_q <= 32'h0000_0000;
			config_q <= 32'h0000_0000;
			shutdown_q <= '0;
			ramp_time_q <= 32'h0000_0000;
			irq_mask_q <= 32'h0000_0000;
			table_q <= '{default: '0};
		end else if (wr_i) begin
			case (addr_i)
				`ADDR_CONTROL: control_q <= wdata_i & `CTRL_MASK;
				`ADDR_CONFIG: config_q <= wdata_i & `CFG_MASK;
				`ADDR_LIMIT0, 8'h14, 8'h18, `ADDR_LIMIT3: table_q[addr_i[3:2]] <= wdata_i[SPEED_W-1:0];
				`ADDR_SHUTDOWN: shutdown_q <= wdata_i[SPEED_W-1:0];
				`ADDR_RAMP_TIMER: ramp_time_q <= wdata_i;
				`ADDR_IRQ_MASK: irq_mask_q <= wdata_i & `IRQ_MASK_BITS;
				default: begin
				end
			endcase
		end
	end

	// Interrupt events, sticky until a one is written back
	always_comb begin
		events = 32'h0000_0000;
		events[`IRQ_VIOLATION_BIT] = violation;
		events[`IRQ_CANCEL_BIT] = (state_q == ST_RAMP) && (state_d == ST_CANCEL);
		events[`IRQ_STANDSTILL_BIT] = (state_q == ST_HOLD) && (state_d == ST_STANDSTILL);
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			irq_status_q <= 32'h0000_0000;
		end else if (wr_i && addr_i == `ADDR_IRQ_STATUS) begin
			irq_status_q <= (irq_status_q & ~wdata_i) | events;
		end else begin
			irq_status_q <= irq_status_q | events;
		end
	end

	// Status words built from the stop state
	always_comb begin
		safety_status = 32'h0000_0000;
		safety_status[`SAFE_TORQUE_OFF_BIT] = (state_q == ST_CANCEL);
		safety_status[`SAFE_RAMP_STOP_BIT] = (state_q == ST_RAMP);
		safety_status[`SAFE_HOLD_BIT] = (state_q == ST_HOLD);
		safety_status[`SAFE_STANDSTILL_BIT] = (state_q == ST_STANDSTILL);
		safety_status[`SAFE_LIMITED_BIT] = mon_active && (state_q != ST_STANDSTILL);
		safety_status[`SAFE_EVENT_BIT] = event_q;
		safety_status[`SAFE_LEVEL_HI:`SAFE_LEVEL_LO] = level_q;
		stop_status = 32'h0000_0000;
		stop_status[`STOP_CANCEL_OR_RAMP_BIT] = (state_q == ST_CANCEL) || (state_q == ST_RAMP);
		stop_status[`STOP_HOLD_BIT] = (state_q == ST_HOLD);
	end
	// Message value is a hundred times one more than the violated level number
	assign msg_value = 16'((msg_level_q + 3'd1) * `MSG_VALUE_STEP);
	always_comb begin
		messages = 32'h0000_0000;
		messages[`MSG_LIMIT_LO +: `CHANNELS] = msg_limit_q;
		messages[`MSG_RAMP_LO +: `CHANNELS] = msg_ramp_q;
		messages[`MSG_CANCEL_LO +: `CHANNELS] = msg_cancel_q;
		messages[`MSG_LEVEL_LO +: 2] = msg_level_q;
		messages[`MSG_VALUE_LO +: 16] = (msg_limit_q != '0) ? msg_value : 16'h0000;
	end

	// Read data one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge mclk_i) begin
		if (rst_i || !rd_i) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			case (addr_i)
				`ADDR_CONTROL: rdata_q <= control_q;
				`ADDR_CONFIG: rdata_q <= config_q;
				8'h10, 8'h14, 8'h18, `ADDR_LIMIT3: rdata_q <= 32'(table_q[addr_i[3:2]]);
				`ADDR_SHUTDOWN: rdata_q <= 32'(shutdown_q);
				`ADDR_RAMP_TIMER: rdata_q <= ramp_time_q;
				`ADDR_SAFETY_STATUS: rdata_q <= safety_status;
				`ADDR_STOP_STATUS: rdata_q <= stop_status;
				`ADDR_MESSAGES: rdata_q <= messages;
				`ADDR_INHIBIT: rdata_q <= {31'h0000_0000, inhibit_q};
				`ADDR_IRQ_STATUS: rdata_q <= irq_status_q;
				`ADDR_IRQ_MASK: rdata_q <= irq_mask_q;
				`ADDR_SPEED: rdata_q <= 32'(speed_i[0]);
				default: rdata_q <= 32'h0000_0000;
			endcase
		end
	end

	// Drive-side outputs
	assign rdata_o = rdata_q;
	assign fast_stop_o = (state_q == ST_RAMP) || (state_q == ST_HOLD);
	assign torque_off_o = (state_q == ST_CANCEL);
	assign standstill_mon_o = (state_q == ST_STANDSTILL);
	assign inhibit_o = inhibit_q;
	assign msg_limit_o = msg_limit_q;
	assign msg_ramp_o = msg_ramp_q;
	assign msg_cancel_o = msg_cancel_q;
	assign msg_value_o = (msg_limit_q != '0) ? msg_value : 16'h0000;
	assign irq_o = |(irq_status_q & irq_mask_q);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	exceed_message_a: assert property (violation |=> (msg_limit_q == '1) && !safety_status[`SAFE_EVENT_BIT])
		else $error("violation without message and event low");
	first_event_a: assert property ($fell(event_q) |-> ($past(msg_limit_q) == '0))
		else $error("internal event changed on a later message");
	ramp_start_a: assert property (violation && response == RESP_RAMP_STOP |=> state_q == ST_RAMP)
		else $error("ramp stop not started");
	ramp_decel_a: assert property (state_q == ST_RAMP |-> fast_stop_o && !torque_off_o)
		else $error("ramp stop not on fast stop ramp");
	cancel_follow_a: assert property (state_q == ST_RAMP && tick_i && (&below) |=> torque_off_o)
		else $error("torque off missed at shutdown speed");
	stop_word_a: assert property ($rose(torque_off_o) |-> stop_status[`STOP_CANCEL_OR_RAMP_BIT]
		&& $past(stop_status[`STOP_CANCEL_OR_RAMP_BIT]))
		else $error("stop status bit dropped between stops");
	torque_bit_a: assert property ($rose(safety_status[`SAFE_TORQUE_OFF_BIT]) |-> $past(state_q == ST_RAMP))
		else $error("torque off bit without ramp stop");
	ramp_bit_a: assert property (violation && response == RESP_RAMP_STOP |=> safety_status[`SAFE_RAMP_STOP_BIT])
		else $error("ramp stop bit not set");
	level_report_a: assert property (state_q == ST_RUN && mon_active |=> safety_status[`SAFE_LEVEL_HI:`SAFE_LEVEL_LO]
		== $past(control_q[`CTRL_LEVEL_HI:`CTRL_LEVEL_LO]))
		else $error("active level not reported");
	cancel_msg_a: assert property ($rose(torque_off_o) |-> (msg_cancel_q == '1) && (msg_ramp_q == '1))
		else $error("cancel message missing on both channels");
	inhibit_hold_a: assert property (torque_off_o && !ack_inhibit |=> inhibit_q && torque_off_o)
		else $error("inhibit released without acknowledge");
	enable_gate_a: assert property (!mon_en && state_q == ST_RUN |=> state_q == ST_RUN)
		else $error("violation while monitor disabled");
	hold_path_a: assert property (violation && response == RESP_STOP_AND_HOLD |=> state_q == ST_HOLD)
		else $error("stop and hold not started");

endmodule : speed_limit_monitor_ramp_stop

// File: rtl/slm_cfg.svh
`ifndef SLM_CFG_SVH
`define SLM_CFG_SVH

// Register byte offsets
`define ADDR_CONTROL 8'h00
`define ADDR_COMMAND 8'h04
`define ADDR_CONFIG 8'h08
`define ADDR_LIMIT0 8'h10
`define ADDR_LIMIT3 8'h1C
`define ADDR_SHUTDOWN 8'h20
`define ADDR_RAMP_TIMER 8'h24
`define ADDR_SAFETY_STATUS 8'h28
`define ADDR_STOP_STATUS 8'h2C
`define ADDR_MESSAGES 8'h30
`define ADDR_INHIBIT 8'h34
`define ADDR_IRQ_STATUS 8'h38
`define ADDR_IRQ_MASK 8'h3C
`define ADDR_SPEED 8'h40

// Safety control word fields
`define CTRL_SELECT_BIT 4
`define CTRL_LEVEL_LO 9
`define CTRL_LEVEL_HI 10
`define CTRL_MASK 32'h0000_0610

// Command register pulses
`define CMD_ACK_MSG_BIT 0
`define CMD_ACK_INHIBIT_BIT 1

// Configuration fields
`define CFG_SAFETY_EN_BIT 0
`define CFG_RESPONSE_BIT 1
`define CFG_EXT_EN_BIT 2
`define CFG_COMM_LO 8
`define CFG_COMM_HI 15
`define CFG_MASK 32'h0000_FF07

// Safety status word fields
`define SAFE_TORQUE_OFF_BIT 0
`define SAFE_RAMP_STOP_BIT 1
`define SAFE_HOLD_BIT 2
`define SAFE_STANDSTILL_BIT 3
`define SAFE_LIMITED_BIT 4
`define SAFE_EVENT_BIT 7
`define SAFE_LEVEL_LO 9
`define SAFE_LEVEL_HI 10

// Stop status word fields
`define STOP_CANCEL_OR_RAMP_BIT 12
`define STOP_HOLD_BIT 13

// Switch-on inhibit register field
`define INHIBIT_BIT 0

// Message register fields
`define MSG_LIMIT_LO 0
`define MSG_RAMP_LO 2
`define MSG_CANCEL_LO 4
`define MSG_LEVEL_LO 8
`define MSG_VALUE_LO 16
`define MSG_VALUE_STEP 16'h0064

// Interrupt status bits
`define IRQ_VIOLATION_BIT 0
`define IRQ_CANCEL_BIT 1
`define IRQ_STANDSTILL_BIT 2
`define IRQ_MASK_BITS 32'h0000_0007

// Structure and timing
`define CHANNELS 2
`define LEVELS 4
`define CLK_FREQ_KHZ 25000
`define HOLD_TIME_MS 500
`define HOLD_CYCLES (`HOLD_TIME_MS * `CLK_FREQ_KHZ)

`endif

// File: rtl/slm_pkg.sv
package slm_pkg;

	// Stop sequence of the monitor
	typedef enum {
		ST_RUN,
		ST_RAMP,
		ST_CANCEL,
		ST_HOLD,
		ST_STANDSTILL
	} stop_state_type;

	// Configured stop response on a violation
	typedef enum logic {
		RESP_RAMP_STOP,
		RESP_STOP_AND_HOLD
	} response_type;

endpackage : slm_pkg

// File: rtl/limit_if.sv
`timescale 1ns/10ps

interface limit_if #(parameter int WIDTH = 32);
	logic tick;
	logic armed;
	logic [WIDTH-1:0] speed;
	logic [WIDTH-1:0] limit;
	logic [WIDTH-1:0] floor;
	logic exceeded;
	logic below;

	modport monitor(output tick, armed, speed, limit, floor, input exceeded, below);
	modport compare(input tick, armed, speed, limit, floor, output exceeded, below);
endinterface : limit_if

// File: rtl/limit_compare.sv
`timescale 1ns/10ps

module limit_compare #(parameter int WIDTH = 32) (
	input wire logic clk_i,
	input wire logic rst_i,
	limit_if.compare port
);

	logic exceeded_q;

	// One comparison per safety cycle tick
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			exceeded_q <= 1'b0;
		end else begin
			exceeded_q <= port.tick && port.armed && (port.speed > port.limit);
		end
	end

	assign port.exceeded = exceeded_q;
	// Shutdown speed check used during the ramp
	assign port.below = port.speed < port.floor;

	detect_tick_a: assert property (@(posedge clk_i) disable iff (rst_i)
		port.tick && port.armed && (port.speed > port.limit) |=> port.exceeded)
		else $error("speed over limit not flagged");

endmodule : limit_compare

// File: tb/drive_model.sv
`timescale 1ns/10ps

// Drive and encoder stand-in: makes the safety cycle tick and moves the speed
module drive_model #(
	parameter int TICK_DIV = 4,
	parameter int STEP = 8
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic fast_stop_i,
	input wire logic torque_off_i,
	input wire logic [31:0] setpoint_i,
	output logic tick_o = 1'b0,
	output logic [1:0][31:0] speed_o
);
	int div_q = 0;
	logic [31:0] spd_q = '0;

	// One clock wide tick every TICK_DIV clocks
	always_ff @(posedge mclk_i) begin
		if (rst_i || div_q == TICK_DIV - 1) begin
			div_q <= 0;
		end else begin
			div_q <= div_q + 1;
		end
		tick_o <= !rst_i && div_q == TICK_DIV - 1;
	end

	// Stops pull the speed down, otherwise it follows the setpoint
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			spd_q <= '0;
		end else if (tick_o) begin
			if (fast_stop_i || torque_off_i) begin
				spd_q <= (spd_q > STEP) ? spd_q - STEP : '0;
			end else if (spd_q + STEP < setpoint_i) begin
				spd_q <= spd_q + STEP;
			end else begin
				spd_q <= setpoint_i;
			end
		end
	end

	// Second channel reads one unit lower
	assign speed_o[0] = spd_q;
	assign speed_o[1] = (spd_q > 0) ? spd_q - 1 : '0;
endmodule : drive_model

// File: tb/speed_limit_monitor_ramp_stop_bench.sv
`timescale 1ns/10ps
`include "slm_cfg.svh"

// Compare with case equality and count
`define CHECK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
$display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end

module speed_limit_monitor_ramp_stop_bench;
	localparam int TD = 4;
	localparam int HOLD = 20;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] addr = '0;
	logic [31:0] wdata = '0;
	logic [31:0] sp = '0;
	logic [31:0] rdata;
	logic tick;
	logic [`CHANNELS-1:0][31:0] speed;
	logic fast_stop, torque_off, standstill, inhibit, irq;
	logic [1:0] msg_limit, msg_ramp, msg_cancel;
	logic [15:0] msg_value;
	int fail_count = 0;
	int num_checks = 0;
	time t_on, t_off, t_ss;

	// Clock and stop edge timestamps
	always #20 mclk = ~mclk;
	always @(posedge fast_stop) t_on = $time;
	always @(posedge torque_off) t_off = $time;
	always @(posedge standstill) t_ss = $time;

	speed_limit_monitor_ramp_stop #(.SPEED_W(32), .HOLD_CYCLES(HOLD)) dut (
		.mclk_i(mclk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
		.rdata_o(rdata), .tick_i(tick), .speed_i(speed), .fast_stop_o(fast_stop),
		.torque_off_o(torque_off), .standstill_mon_o(standstill), .inhibit_o(inhibit),
		.msg_limit_o(msg_limit), .msg_ramp_o(msg_ramp), .msg_cancel_o(msg_cancel),
		.msg_value_o(msg_value), .irq_o(irq)
	);

	drive_model #(.TICK_DIV(TD), .STEP(8)) drive (
		.mclk_i(mclk), .rst_i(rst), .fast_stop_i(fast_stop), .torque_off_i(torque_off),
		.setpoint_i(sp), .tick_o(tick), .speed_o(speed)
	);

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : print_verdict

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge mclk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge mclk);
		rd <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd <= 1'b0;
		@(negedge mclk);
		`CHECK(rdata & m, e)
	endtask : rd_reg

	// Select a level, drive just over its limit, check the first response
	task automatic violate(input int lvl);
		logic [31:0] lim;
		int n;
		lim = 32'(100 * (lvl + 1));
		wr_reg(`ADDR_CONTROL, 32'h0000_0010 | (32'(lvl) << 9));
		rd_reg(`ADDR_SAFETY_STATUS, 32'h0000_0690, 32'h0000_0090 | (32'(lvl) << 9));
		@(posedge mclk);
		sp <= lim + 5;
		for (n = 0; n < 3000 && !(speed[0] > lim); n++) @(negedge mclk);
		for (n = 0; n < 50 && !fast_stop; n++) @(negedge mclk);
		`CHECK(n, TD + 1)
		`CHECK(msg_limit, 2'b11)
		`CHECK(msg_value, 16'(100 * (lvl + 1)))
		`CHECK(irq, 1'b1)
	endtask : violate

	// Wait for torque off, check it, then recover as the controller
	task automatic finish_stop();
		int n;
		for (n = 0; n < 3000 && !torque_off; n++) @(negedge mclk);
		`CHECK(torque_off, 1'b1)
		`CHECK(fast_stop, 1'b0)
		`CHECK(msg_cancel, 2'b11)
		`CHECK(inhibit, 1'b1)
		rd_reg(`ADDR_SAFETY_STATUS, 32'h0000_0083, 32'h0000_0001);
		rd_reg(`ADDR_STOP_STATUS, 32'h0000_1000, 32'h0000_1000);
		rd_reg(`ADDR_INHIBIT, 32'h0000_0001, 32'h0000_0001);
		wr_reg(`ADDR_IRQ_STATUS, 32'h0000_0001);
		rd_reg(`ADDR_IRQ_STATUS, 32'h0000_0007, 32'h0000_0002);
		`CHECK(irq, 1'b0)
		wr_reg(`ADDR_IRQ_STATUS, 32'h0000_0002);
		wr_reg(`ADDR_COMMAND, 32'h0000_0002);
		@(negedge mclk);
		`CHECK(inhibit, 1'b1)
		wr_reg(`ADDR_CONTROL, 32'h0000_0000);
		wr_reg(`ADDR_COMMAND, 32'h0000_0001);
		rd_reg(`ADDR_SAFETY_STATUS, 32'h0000_0080, 32'h0000_0080);
		`CHECK(msg_limit, 2'b00)
		wr_reg(`ADDR_COMMAND, 32'h0000_0002);
		@(negedge mclk);
		@(negedge mclk);
		`CHECK({inhibit, torque_off}, 2'b00)
		sp <= '0;
		repeat (400) @(posedge mclk);
	endtask : finish_stop

	// Watchdog well beyond the expected run length
	initial begin
		repeat (40000) @(posedge mclk);
		fail_count++;
		print_verdict();
	end

	initial begin
		logic [31:0] bad_cfg [3];
		bad_cfg = '{32'h0000_0105, 32'h0000_0001, 32'h0000_0004};
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		rd_reg(`ADDR_SAFETY_STATUS, 32'hFFFF_FFFF, 32'h0000_0080);
		rd_reg(`ADDR_MESSAGES, 32'hFFFF_FFFF, 32'h0000_0000);
		rd_reg(8'h44, 32'hFFFF_FFFF, 32'h0000_0000);
		rd_reg(`ADDR_SPEED, 32'hFFFF_FFFF, 32'h0000_0000);
		wr_reg(`ADDR_CONFIG, 32'hFFFF_FFFF);
		rd_reg(`ADDR_CONFIG, 32'hFFFF_FFFF, 32'h0000_FF07);
		for (int l = 0; l < 4; l++) wr_reg(8'(`ADDR_LIMIT0 + 4 * l), 32'(100 * (l + 1)));
		wr_reg(`ADDR_SHUTDOWN, 32'h0000_0014);
		wr_reg(`ADDR_RAMP_TIMER, 32'h0000_03E8);
		wr_reg(`ADDR_IRQ_MASK, 32'h0000_0001);
		// Monitoring stays quiet unless fully enabled
		wr_reg(`ADDR_CONTROL, 32'h0000_0010);
		sp <= 32'h0000_0096;
		foreach (bad_cfg[i]) begin
			wr_reg(`ADDR_CONFIG, bad_cfg[i]);
			repeat (120) @(posedge mclk);
			`CHECK({fast_stop, msg_limit}, 3'b000)
			rd_reg(`ADDR_SAFETY_STATUS, 32'h0000_0010, 32'h0000_0000);
		end
		sp <= '0;
		wr_reg(`ADDR_CONTROL, 32'h0000_0000);
		repeat (200) @(posedge mclk);
		wr_reg(`ADDR_CONFIG, 32'h0000_0005);
		// Every level, ended by the shutdown speed
		for (int l = 0; l < 4; l++) begin
			violate(l);
			`CHECK(msg_ramp, 2'b11)
			rd_reg(`ADDR_SAFETY_STATUS, 32'h0000_0083, 32'h0000_0002);
			rd_reg(`ADDR_STOP_STATUS, 32'h0000_1000, 32'h0000_1000);
			rd_reg(`ADDR_MESSAGES, 32'h0000_033F, 32'h0000_000F | (32'(l) << 8));
			finish_stop();
		end
		// Short ramp timer ends the ramp first
		wr_reg(`ADDR_RAMP_TIMER, 32'h0000_000A);
		violate(3);
		finish_stop();
		`CHECK((t_off - t_on) >= 400 && (t_off - t_on) <= 40 * (13 + TD), 1'b1)
		// Other response: stop and hold, then standstill
		wr_reg(`ADDR_CONFIG, 32'h0000_0007);
		violate(0);
		`CHECK(torque_off, 1'b0)
		rd_reg(`ADDR_STOP_STATUS, 32'h0000_3000, 32'h0000_2000);
		for (int n = 0; n < 200 && !standstill; n++) @(negedge mclk);
		`CHECK((t_ss - t_on) >= 40 * (HOLD - 1) && (t_ss - t_on) <= 40 * (HOLD + 2), 1'b1)
		rd_reg(`ADDR_SAFETY_STATUS, 32'h0000_001F, 32'h0000_0008);
		wr_reg(`ADDR_CONTROL, 32'h0000_0000);
		wr_reg(`ADDR_COMMAND, 32'h0000_0001);
		repeat (2) @(negedge mclk);
		`CHECK(standstill, 1'b0)
		print_verdict();
	end
endmodule : speed_limit_monitor_ramp_stop_bench
